// ---- atwr_readout.sv ----
`timescale 1ns/1ps
`include "atwr_cfg.svh"

// Behaviour
// RULE_01: Low on ready/data line means new result
// RULE_02: Line changes only on serial clock falling edge; code also changes it at conversion end and on sleep entry
// RULE_03: External clock stops internal oscillator, drives timing
// RULE_04: Power-on reset runs self-calibration before results
// RULE_05: Host requests calibration with 26 clock pulses
// RULE_06: Single-cycle mode clears lowpass filter each conversion
// RULE_07: Continuous mode keeps lowpass filter state
// RULE_08: Fixed output rate per variant, not programmable
// RULE_09: Line idles high, low at conversion end
// RULE_10: Twenty-fifth pulse after 18 bits returns high
// RULE_11: All control only by serial clock phase timing
// RULE_12: Link outputs data only, accepts none
// RULE_13: Timing divided down from system clock
// RULE_14: Result shifted out MSB first, two's complement
// RULE_15: Unread result overwritten by newer conversion
// RULE_16: Clock held high sleeps; low wakes, converts
// RULE_17: Host waits for low, samples after update
module atwr_readout #(
	parameter int CONV_TICKS = int'(64'(`ATWR_OSC_HZ) * 64'd1000 / 64'(`ATWR_RATE_MSPS)),
	parameter int CAL_TICKS = int'(64'(`ATWR_OSC_HZ) * 64'(`ATWR_CAL_TIME_US) / 64'd1000000)
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic sclkIn,
	input wire logic extClkIn,
	input wire logic singleCycle,
	input wire atwr_pkg::atwr_word_type sampleData,
	input wire logic sampleValid,
	output logic sampleReady,
	output logic rdyDout_q,
	output logic oscEnable_q,
	output logic filterClear_q,
	output logic calBusy_q,
	output logic sleeping_q
);
	import atwr_pkg::*;

	// Pulses 1..18 carry data bits
	function automatic logic isDataPulse(input logic [`ATWR_PULSE_W-1:0] n);
		isDataPulse = (n >= `ATWR_PULSE_FIRST) && (n <= `ATWR_PULSE_LAST);
	endfunction

	// Sequencer state
	atwr_state_type state_q;
	atwr_state_type state_d;
	// System clock ticks within current phase
	logic [`ATWR_TICK_W-1:0] tickCnt_q;
	logic [`ATWR_TICK_W-1:0] tickCnt_d;
	// Serial pulses seen since data became ready
	logic [`ATWR_PULSE_W-1:0] pulseCnt_q;
	logic [`ATWR_PULSE_W-1:0] pulseCnt_d;
	// Core cycles with serial clock held high
	logic [`ATWR_HIGH_W-1:0] highCnt_q;
	logic [`ATWR_HIGH_W-1:0] highCnt_d;
	// Latest result and the copy being shifted
	atwr_word_type result_q;
	atwr_word_type result_d;
	atwr_word_type shift_q;
	atwr_word_type shift_d;
	// A readout window is open
	logic avail_q;
	logic avail_d;
	logic rdyDout_d;
	logic sclkPrev_q;
	// Decoded events
	logic sclkRise;
	logic sclkFall;
	logic sysTick;
	logic extActive;
	logic convDone;
	logic calDone;
	logic popWord;
	logic calKick;
	logic sleepEnter;
	logic wake;
	logic phaseChange;
	// Falling edge of a data pulse inside an open window
	logic dataFall;
	// Buffer drain side
	atwr_word_type bufOutData;
	logic bufOutValid;

	// System clock source: internal divider or external pin
	atwr_sys_tick u_tick (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.extClkIn(extClkIn),
		.sysTick(sysTick),
		.extActive(extActive)
	);

	// Filter words wait here; drained once per conversion end
	atwr_pair_buf u_buf (
		.clk(clk),
		.srst(srst),
		.ce(ce),
		.inData(sampleData),
		.inValid(sampleValid),
		.inReady(sampleReady),
		.outData(bufOutData),
		.outValid(bufOutValid),
		.outReady(convDone)
	);

	// Serial clock is the only input of the link
	assign sclkRise = sclkIn & ~sclkPrev_q; // RULE_12
	assign sclkFall = ~sclkIn & sclkPrev_q; // RULE_02

	// Conversion period fixed by the tick count; a calibration or sleep
	// request in the same cycle wins, so no result lands mid-change
	assign convDone = (state_q == ATWR_CONV) && sysTick && !calKick && !sleepEnter
		&& (tickCnt_q == `ATWR_TICK_W'(CONV_TICKS - 1)); // RULE_08
	assign calDone = (state_q == ATWR_CAL) && sysTick
		&& (tickCnt_q == `ATWR_TICK_W'(CAL_TICKS - 1));
	// Empty buffer at conversion end yields no new result
	assign popWord = convDone & bufOutValid;
	// Falling edge of pulse 26 starts calibration
	assign calKick = sclkFall && (pulseCnt_q == `ATWR_PULSE_CAL)
		&& (state_q == ATWR_CONV); // RULE_05 RULE_11
	// Long high phase after data ready means sleep
	assign sleepEnter = (state_q == ATWR_CONV) && avail_q && sclkIn
		&& (highCnt_q == `ATWR_HIGH_W'(`ATWR_SLEEP_CYC - 1)); // RULE_16 RULE_11
	assign wake = (state_q == ATWR_SLEEP) && !sclkIn; // RULE_16
	// Window gate keeps the wake-up fall from shifting a stale bit out
	assign dataFall = sclkFall && avail_q && isDataPulse(pulseCnt_q); // RULE_09

	// Phase sequencing
	assign state_d = calKick ? ATWR_CAL
		: calDone ? ATWR_CONV
		: sleepEnter ? ATWR_SLEEP
		: wake ? ATWR_CONV
		: state_q;
	assign phaseChange = (state_d != state_q);

	// Timer restarts on each phase and each finished conversion
	assign tickCnt_d = (phaseChange || convDone) ? '0
		: sysTick ? tickCnt_q + `ATWR_TICK_W'(1)
		: tickCnt_q; // RULE_13

	// Newer result replaces an unread one
	assign result_d = popWord ? bufOutData : result_q; // RULE_15

	// Pulse count saturates at the calibration pulse
	assign pulseCnt_d = (popWord || calKick || wake) ? `ATWR_PULSE_IDLE
		: (sclkRise && avail_q && (pulseCnt_q < `ATWR_PULSE_CAL))
			? pulseCnt_q + `ATWR_PULSE_W'(1)
		: pulseCnt_q;

	// Copy taken on the first rising edge, shifted on falling edges
	assign shift_d = (sclkRise && avail_q && (pulseCnt_q == `ATWR_PULSE_IDLE)) ? result_q
		: dataFall ? {shift_q[`ATWR_DATA_W-2:0], 1'b0}
		: shift_q; // RULE_14

	// Set wins: a new result reopens the window
	assign avail_d = popWord ? 1'b1
		: (calKick || sleepEnter) ? 1'b0
		: avail_q;

	// Count a held-high clock only while a result waits
	assign highCnt_d = (sclkIn && avail_q && (state_q == ATWR_CONV)
		&& (highCnt_q != `ATWR_HIGH_W'(`ATWR_SLEEP_CYC - 1)))
		? highCnt_q + `ATWR_HIGH_W'(1) : '0;

	// Ready/data line: low on result, bits on falls, high on release
	assign rdyDout_d = popWord ? 1'b0 // RULE_01 RULE_09
		: (sleepEnter || calKick) ? 1'b1 // RULE_16
		: dataFall ? shift_q[`ATWR_DATA_W-1] // RULE_02 RULE_14
		: (sclkFall && (pulseCnt_q == `ATWR_PULSE_RELEASE)) ? 1'b1 // RULE_10
		: rdyDout_q; // RULE_09

	// Sequencer and timers; reset enters calibration
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= ATWR_CAL; // RULE_04
			tickCnt_q <= '0;
			pulseCnt_q <= `ATWR_PULSE_IDLE;
			highCnt_q <= '0;
			avail_q <= 1'b0;
		end
		else if (ce)
		begin
			state_q <= state_d;
			tickCnt_q <= tickCnt_d;
			pulseCnt_q <= pulseCnt_d;
			highCnt_q <= highCnt_d;
			avail_q <= avail_d;
		end
	end

	// Data path registers; no reset needed on the words
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			result_q <= result_d;
			shift_q <= shift_d;
		end
	end

	// Pin and status outputs, all registered
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sclkPrev_q <= 1'b0;
			rdyDout_q <= 1'b1;
			oscEnable_q <= 1'b1;
			filterClear_q <= 1'b0;
			calBusy_q <= 1'b1;
			sleeping_q <= 1'b0;
		end
		else if (ce)
		begin
			sclkPrev_q <= sclkIn;
			rdyDout_q <= rdyDout_d;
			oscEnable_q <= !extActive; // RULE_03
			filterClear_q <= convDone & singleCycle; // RULE_06 RULE_07
			calBusy_q <= (state_d == ATWR_CAL);
			sleeping_q <= (state_d == ATWR_SLEEP);
		end
	end

	// Checks, all in the core clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst || !ce);

	// Word a burst started with, held so the first-bit check can see it
	atwr_word_type burstWord_q;
	always_ff @(posedge clk)
	begin
		if (ce && sclkRise && avail_q && (pulseCnt_q == `ATWR_PULSE_IDLE))
			burstWord_q <= result_q;
	end

	// Burst reaches pulse 25 then falls
	sequence s_release;
		sclkFall && (pulseCnt_q == `ATWR_PULSE_RELEASE) && !popWord && !sleepEnter;
	endsequence

	// Pulse 26 falling edge in conversion
	sequence s_calKick;
		sclkFall && (pulseCnt_q == `ATWR_PULSE_CAL) && (state_q == ATWR_CONV);
	endsequence

	// First falling edge of a burst with the window still open
	sequence s_firstFall;
		sclkFall && avail_q && (pulseCnt_q == `ATWR_PULSE_FIRST) && !popWord;
	endsequence

	a_ready_low: assert property (popWord |=> !rdyDout_q && avail_q) // RULE_01 RULE_09
		else $error("result ready but line not low");

	a_change_fall: assert property ($changed(rdyDout_q) // RULE_02
		&& !$past(popWord) && !$past(sleepEnter) && !$past(calKick)
		|-> $past(sclkFall))
		else $error("line changed without a falling edge");

	a_release_high: assert property (s_release |=> rdyDout_q) // RULE_10
		else $error("pulse 25 did not release the line");

	a_cal_start: assert property (s_calKick |=> calBusy_q && rdyDout_q // RULE_05
		&& (pulseCnt_q == `ATWR_PULSE_IDLE))
		else $error("pulse 26 did not start calibration");

	a_msb_first: assert property (s_firstFall |=> // RULE_14
		rdyDout_q == burstWord_q[`ATWR_DATA_W-1])
		else $error("first bit is not the result MSB");

	a_filter_mode: assert property (convDone |=> filterClear_q == $past(singleCycle)) // RULE_06 RULE_07
		else $error("filter clear does not follow mode");

	a_overwrite: assert property (popWord |=> result_q == $past(bufOutData)) // RULE_15
		else $error("new result not stored");

	a_por_cal: assert property ($fell(srst) |-> calBusy_q && rdyDout_q // RULE_04
		&& (state_q == ATWR_CAL))
		else $error("reset did not enter calibration");

	a_sleep_high: assert property (sleepEnter |=> rdyDout_q && sleeping_q // RULE_16
		##1 (sleeping_q || !$past(sclkIn)))
		else $error("sleep entry did not raise the line");

	a_osc_stop: assert property (extActive |=> !oscEnable_q) // RULE_03
		else $error("internal oscillator left running");

	// Waking leaves the line idle until a fresh result lands
	a_wake_high: assert property (wake |=> rdyDout_q) // RULE_09 RULE_16
		else $error("line dropped on wake without a result");

	// No result may show while calibrating
	a_cal_quiet: assert property (calBusy_q |-> rdyDout_q) // RULE_04
		else $error("line low during calibration");
endmodule // atwr_readout

// ---- atwr_cfg.svh ----
`ifndef ATWR_CFG_SVH
`define ATWR_CFG_SVH

// Result word width
`define ATWR_DATA_W 18
// Core clock rate in Hz
`define ATWR_CLK_HZ 25000000
// System clock rate in Hz (second variant runs at 2252800)
`define ATWR_OSC_HZ 2457600
// Output rate in milli-samples per second (second variant 13750)
`define ATWR_RATE_MSPS 120000
// Calibration time in microseconds
`define ATWR_CAL_TIME_US 200000
// Serial clock high time that enters sleep, in ns
`define ATWR_SLEEP_TIME_NS 100000
// Least high time, rounded up to core cycles
`define ATWR_SLEEP_CYC ((`ATWR_SLEEP_TIME_NS * (`ATWR_CLK_HZ / 1000000) + 999) / 1000)
// Silence on the external clock pin that means it is gone, in ns
`define ATWR_EXT_LOSS_NS 2000
// Longest silence, rounded down to core cycles
`define ATWR_EXT_LOSS_CYC (`ATWR_EXT_LOSS_NS * (`ATWR_CLK_HZ / 1000000) / 1000)
// Serial pulse numbers of a readout burst
`define ATWR_PULSE_W 5
`define ATWR_PULSE_IDLE 5'd0
`define ATWR_PULSE_FIRST 5'd1
`define ATWR_PULSE_LAST 5'd18
`define ATWR_PULSE_RELEASE 5'd25
`define ATWR_PULSE_CAL 5'd26
// Timer widths
`define ATWR_TICK_W 24
`define ATWR_HIGH_W 12
`define ATWR_LOSS_W 8
`define ATWR_ACC_W 25
// Two-entry buffer occupancy
`define ATWR_BUF_FULL 2'd2
`define ATWR_BUF_EMPTY 2'd0

`endif

// ---- atwr_pkg.sv ----
`include "atwr_cfg.svh"

package atwr_pkg;
	// One conversion result
	typedef logic [`ATWR_DATA_W-1:0] atwr_word_type;
	// Converter sequencing
	typedef enum logic [1:0] {ATWR_CAL, ATWR_CONV, ATWR_SLEEP} atwr_state_type;
endpackage

// ---- atwr_pair_buf.sv ----
`timescale 1ns/1ps
`include "atwr_cfg.svh"

module atwr_pair_buf (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire atwr_pkg::atwr_word_type inData,
	input wire logic inValid,
	output logic inReady,
	output atwr_pkg::atwr_word_type outData,
	output logic outValid,
	input wire logic outReady
);
	import atwr_pkg::*;

	// Storage and pointers
	atwr_word_type slot_q [2];
	logic wrPtr_q;
	logic rdPtr_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic push;
	logic pop;

	assign push = inValid & inReady;
	assign pop = outValid & outReady;
	assign outValid = (cnt_q != `ATWR_BUF_EMPTY);
	assign outData = slot_q[rdPtr_q];
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	// Each slot written only when the write pointer points at it
	for (genvar i = 0; i < 2; i++)
	begin : g_slot
		always_ff @(posedge clk)
		begin
			if (ce && push && (wrPtr_q == 1'(i)))
				slot_q[i] <= inData;
		end
	end

	// Ready is registered, so it reflects the count after this edge
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
			cnt_q <= `ATWR_BUF_EMPTY;
			inReady <= 1'b0;
		end
		else if (ce)
		begin
			wrPtr_q <= wrPtr_q ^ push;
			rdPtr_q <= rdPtr_q ^ pop;
			cnt_q <= cnt_d;
			inReady <= (cnt_d != `ATWR_BUF_FULL);
		end
	end

	a_buf_full: assert property (@(posedge clk) disable iff (srst || !ce)
		(cnt_q == `ATWR_BUF_FULL) |-> !inReady)
		else $error("buffer full but still ready");
endmodule // atwr_pair_buf

// ---- atwr_sys_tick.sv ----
`timescale 1ns/1ps
`include "atwr_cfg.svh"

module atwr_sys_tick (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic extClkIn,
	output logic sysTick,
	output logic extActive
);
	// Previous external clock level
	logic extPrev_q;
	// Cycles since the last external edge
	logic [`ATWR_LOSS_W-1:0] lossCnt_q;
	// Fractional divider accumulator
	logic [`ATWR_ACC_W-1:0] acc_q;
	logic [`ATWR_ACC_W-1:0] accSum;
	logic accWrap;
	logic extRise;

	assign extRise = extClkIn & ~extPrev_q;
	// Core rate is not a multiple of the system rate, so accumulate
	assign accSum = acc_q + `ATWR_ACC_W'(`ATWR_OSC_HZ);
	assign accWrap = (accSum >= `ATWR_ACC_W'(`ATWR_CLK_HZ));

	// External edges take over and stop the internal divider
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			extPrev_q <= 1'b0;
			lossCnt_q <= '0;
			acc_q <= '0;
			sysTick <= 1'b0;
			extActive <= 1'b0;
		end
		else if (ce)
		begin
			extPrev_q <= extClkIn;
			lossCnt_q <= extRise ? '0 : lossCnt_q + `ATWR_LOSS_W'(!extActive ? 0 : 1);
			extActive <= extRise | (extActive & (lossCnt_q < `ATWR_LOSS_W'(`ATWR_EXT_LOSS_CYC)));
			acc_q <= extActive ? '0 : (accWrap ? accSum - `ATWR_ACC_W'(`ATWR_CLK_HZ) : accSum); // RULE_13
			sysTick <= extActive ? extRise : accWrap; // RULE_03
		end
	end
endmodule // atwr_sys_tick

// ---- atwr_host_model.sv ----
`timescale 1ns/1ps

module atwr_host_model (
	input wire logic clk,
	input wire logic rdyDout,
	output logic sclk
);
	import atwr_pkg::*;
	// Serial clock rests low between bursts
	initial sclk = 1'b0;
	// Readout burst of n pulses, h core cycles per phase
	task automatic burst(input int n, input int h, output atwr_word_type w);
		int k;
		int t;
		w = '0;
		t = 0;
		// No burst before the ready level shows
		while (rdyDout !== 1'b0 && t < 5000)
		begin
			@(negedge clk);
			t++;
		end
		// Control only by phase timing; 25 releases, 26 calibrates
		for (k = 1; k <= n; k++)
		begin
			// Sampled a full low phase after the fall, so settled
			if (k >= 2 && k <= 19)
				w[19 - k] = rdyDout;
			sclk = 1'b1;
			repeat (h) @(negedge clk);
			sclk = 1'b0;
			repeat (h) @(negedge clk);
		end
	endtask
	// Long high phase asks for sleep, low wakes
	task automatic setLevel(input logic v);
		sclk = v;
	endtask
endmodule // atwr_host_model

// ---- atwr_readout_tb_top.sv ----
`timescale 1ns/1ps

module atwr_readout_tb_top;
	import atwr_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic sclkIn;
	logic extClkIn = 1'b0;
	logic singleCycle = 1'b0;
	atwr_word_type sampleData = '0;
	logic sampleValid = 1'b0;
	logic sampleReady;
	logic rdyDout;
	logic oscEnable;
	logic filterClear;
	logic calBusy;
	logic sleeping;
	atwr_word_type got;
	int badCount = 0;
	int checkCount = 0;
	// Short counts keep the run small
	atwr_readout #(.CONV_TICKS(40), .CAL_TICKS(30)) u_dut (.clk(clk), .srst(srst), .ce(ce),
		.sclkIn(sclkIn), .extClkIn(extClkIn), .singleCycle(singleCycle),
		.sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady),
		.rdyDout_q(rdyDout), .oscEnable_q(oscEnable), .filterClear_q(filterClear),
		.calBusy_q(calBusy), .sleeping_q(sleeping));
	atwr_host_model u_host (.clk(clk), .rdyDout(rdyDout), .sclk(sclkIn));
	// 40 ns core clock
	initial
	begin
		forever #20 clk = ~clk;
	end
	// Compare and count
	task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			badCount++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checkCount, badCount);
		if (badCount == 0 && checkCount > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Bounded wait for the ready level
	task automatic waitRdyLow(input int lim);
		int n;
		n = 0;
		while (rdyDout !== 1'b0 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	// Bounded wait for a conversion-end clear pulse
	task automatic waitClear();
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end while (filterClear !== 1'b1 && n < 2000);
	endtask
	// Offer a word and keep valid up until taken; caller drops valid
	task automatic push(input atwr_word_type w);
		int n;
		n = 0;
		sampleData = w;
		sampleValid = 1'b1;
		while (sampleReady !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
	endtask
	task automatic testReset();
		check("rdy", rdyDout, 18'h00001);
		check("cal", calBusy, 18'h00001);
		check("osc", oscEnable, 18'h00001);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		check("ready", sampleReady, 18'h00001);
	endtask
	// Full buffer, unread result overwritten by the next one
	task automatic testOverwrite();
		singleCycle = 1'b1;
		waitClear();
		check("clear", filterClear, 18'h00001);
		push(18'h20001);
		push(18'h1fffe);
		sampleValid = 1'b0;
		check("full", sampleReady, 18'h00000);
		waitRdyLow(1000);
		check("rdy", rdyDout, 18'h00000);
		@(negedge clk);
		check("drain", sampleReady, 18'h00001);
		waitClear();
		repeat (2) @(negedge clk);
		u_host.burst(25, 3, got);
		check("word", got, 18'h1fffe);
		check("rdy", rdyDout, 18'h00001);
	endtask
	// Slow 26-pulse read starts calibration
	task automatic testCal();
		waitClear();
		push(18'h2aaaa);
		sampleValid = 1'b0;
		u_host.burst(26, 5, got);
		check("word", got, 18'h2aaaa);
		check("cal", calBusy, 18'h00001);
		check("rdy", rdyDout, 18'h00001);
		push(18'h15555);
		sampleValid = 1'b0;
		u_host.burst(25, 3, got);
		check("word", got, 18'h15555);
	endtask
	// Continuous mode never clears the filter
	task automatic testContinuous();
		int n;
		n = 0;
		singleCycle = 1'b0;
		repeat (1000)
		begin
			@(negedge clk);
			if (filterClear === 1'b1)
				n++;
		end
		check("clears", 18'(n), 18'h00000);
	endtask
	task automatic testSleep();
		push(18'h00001);
		sampleValid = 1'b0;
		waitRdyLow(1000);
		u_host.setLevel(1'b1);
		repeat (2600) @(negedge clk);
		check("sleep", sleeping, 18'h00001);
		check("rdy", rdyDout, 18'h00001);
		u_host.setLevel(1'b0);
		repeat (4) @(negedge clk);
		check("wake", sleeping, 18'h00000);
		check("rdy", rdyDout, 18'h00001);
	endtask
	// External clock stops the oscillator, loss restarts it
	task automatic testExtClock();
		repeat (40)
		begin
			extClkIn = ~extClkIn;
			repeat (5) @(negedge clk);
		end
		check("osc", oscEnable, 18'h00000);
		repeat (100) @(negedge clk);
		check("osc", oscEnable, 18'h00001);
	endtask
	// Reset in mid-run: line high, calibration, then a clean read
	task automatic testMidReset();
		push(18'h00002);
		sampleValid = 1'b0;
		waitRdyLow(1000);
		check("rdy", rdyDout, 18'h00000);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		check("rdy", rdyDout, 18'h00001);
		check("cal", calBusy, 18'h00001);
		srst = 1'b0;
		push(18'h2d2d2);
		sampleValid = 1'b0;
		u_host.burst(25, 3, got);
		check("word", got, 18'h2d2d2);
	endtask
	initial
	begin
		repeat (10) @(negedge clk);
		testReset();
		testOverwrite();
		testCal();
		testContinuous();
		testSleep();
		testExtClock();
		testMidReset();
		reportAndStop();
	end
	// Hang guard, well past the expected run
	initial
	begin
		#1200000;
		badCount++;
		reportAndStop();
	end
endmodule // atwr_readout_tb_top
